// ==== pkg/pcs_defs.svh ====
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Widths of a program memory word, an address part and a page part
`define PCS_WORD_W 10
`define PCS_ADDR_W 6
`define PCS_PAGE_W 5

// Highest page that may hold instructions
`define PCS_PAGE_MAX 5'h1F

// Fetch counter value after reset
`define PCS_RST_PAGE 5'h00
`define PCS_RST_ADDR 6'h3F

// Destination select bits in a fetched constant
`define PCS_DEST_ACC_BIT 8
`define PCS_DEST_IO_BIT 9

// Operand field of the pattern fetch and table jump
`define PCS_OPND_LSB 0
`define PCS_OPND_W 3
`define PCS_PAT_AREA_BIT 2

// Instruction cycles spent on one pattern fetch
`define PCS_PAT_CYCLES 2

`endif

// ==== pkg/pcs_pkg.sv ====
package pcs_pkg;

   // Instruction class presented by the decoder for the word in rom_data
   typedef enum logic [2:0] {
      op_none,
      op_in_page_jump,
      op_page_preload,
      op_table_jump,
      op_pattern_fetch
   } pcs_op_e;

   // Run executes one instruction a cycle; pat_second is the constant read
   typedef enum logic {
      st_run,
      st_pat_second
   } pcs_state_e;

endpackage : pcs_pkg

// ==== logic/pcs_poly_step.sv ====
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_poly_step (
   // Present count
   input wire logic [`PCS_ADDR_W-1:0] cur,
   // Following count
   output logic [`PCS_ADDR_W-1:0] nxt
);

   logic fb;

   // Shift left with xnor feedback; the all-ones low field splices in 3F
   assign fb = ~(cur[5] ^ cur[4]) ^ (&cur[4:0]);
   assign nxt = {cur[4:0], fb};

endmodule : pcs_poly_step

// ==== logic/pcs_mix_addr.sv ====
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_mix_addr (
   // Present page
   input wire logic [`PCS_PAGE_W-1:0] cur_page,
   // Modifier sources
   input wire logic [3:0] acc,
   input wire logic [3:0] aux,
   input wire logic carry,
   input wire logic [`PCS_OPND_W-1:0] opnd,
   // Effective address
   output logic [`PCS_PAGE_W:0] eff_page,
   output logic [`PCS_ADDR_W-1:0] eff_addr
);

   logic [`PCS_PAGE_W-1:0] page_mask;

   // Address part from the accumulator and the low auxiliary bits
   assign eff_addr = {aux[1:0], acc};
   assign page_mask = {opnd[1], opnd[0], carry, aux[3], aux[2]};
   // Top operand bit lifts the page into the pattern-only area
   assign eff_page = {opnd[`PCS_PAT_AREA_BIT], cur_page | page_mask};

endmodule : pcs_mix_addr

// ==== logic/pcs_sequencer.sv ====
`timescale 1ns/1ps
`include "pcs_defs.svh"

// Notes on behaviour
// - Page part holds until reloaded; range 0-31
// - Address part: 6-bit polynomial counter, steps once per instruction
// - Counter cycles all 64 values, never carries
// - Program memory words are 10 bits
// - Pages 0-31 program, 32-63 pattern only
// - Pattern address: accumulator, auxiliary, carry, operand mix
// - 3-bit operand; top bit selects pattern area
// - Pattern fetch leaves fetch counter advancing normally
// - Pattern fetch takes two instruction cycles
// - No interrupt taken in pattern second cycle
// - Constant top bits route to accumulator, latches
// - In-page jump loads low six bits
// - In-page jump needs flag; skip sets flag
// - Page preload lands one instruction late
// - Page preload needs flag; skip keeps flag 0
// - Far jump is preload then in-page jump
// - Table jump loads mixed address and page
// - Table jump unconditional, status flag untouched
module pcs_sequencer (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Program and pattern memory
   input wire logic [`PCS_WORD_W-1:0] rom_data,
   output logic [`PCS_PAGE_W:0] rom_page,
   output logic [`PCS_ADDR_W-1:0] rom_word,
   // Decoded instruction and data path operands
   input wire pcs_pkg::pcs_op_e op,
   input wire logic [3:0] acc_in,
   input wire logic [3:0] aux_in,
   input wire logic carry_in,
   // Status flag load from the arithmetic unit
   input wire logic status_load,
   input wire logic status_value,
   // Fetch counter and control state
   output logic [`PCS_PAGE_W-1:0] fetch_page,
   output logic [`PCS_ADDR_W-1:0] fetch_addr,
   output logic status_flag,
   output logic preload_pending,
   output logic int_hold,
   // Pattern destinations
   output logic acc_load,
   output logic [3:0] acc_value,
   output logic [3:0] aux_value,
   output logic io_load,
   output logic [3:0] io_latch_two,
   output logic [3:0] io_latch_three
);

   pcs_pkg::pcs_state_e state;
   pcs_pkg::pcs_state_e next_state;
   logic [`PCS_ADDR_W-1:0] succ_addr;
   logic [`PCS_PAGE_W:0] mix_page;
   logic [`PCS_ADDR_W-1:0] mix_addr;
   logic [`PCS_PAGE_W-1:0] preload_page;
   logic in_run;
   logic jump_take;
   logic preload_take;
   logic instr_done;
   logic preload_apply;
   logic [`PCS_PAGE_W-1:0] next_page;
   logic [`PCS_ADDR_W-1:0] next_addr;
   logic [`PCS_PAGE_W:0] next_rom_page;
   logic [`PCS_ADDR_W-1:0] next_rom_word;
   logic next_status;

   // Bit order of the 4-bit fields in a constant is mirrored on the way out, except for aux_value
   function automatic logic [3:0] pcs_mirror(input logic [3:0] v);
      pcs_mirror = {v[0], v[1], v[2], v[3]};
   endfunction : pcs_mirror

   pcs_poly_step u_step (
      .cur(fetch_addr),
      .nxt(succ_addr)
   );

   pcs_mix_addr u_mix (
      .cur_page(fetch_page),
      .acc(acc_in),
      .aux(aux_in),
      .carry(carry_in),
      .opnd(rom_data[`PCS_OPND_LSB +: `PCS_OPND_W]),
      .eff_page(mix_page),
      .eff_addr(mix_addr)
   );

   assign in_run = (state == pcs_pkg::st_run);
   assign jump_take = in_run && (op == pcs_pkg::op_in_page_jump)
      && status_flag;
   assign preload_take = in_run && (op == pcs_pkg::op_page_preload)
      && status_flag;
   // An instruction completes every run cycle except the first of a fetch
   assign instr_done = !in_run || (op != pcs_pkg::op_pattern_fetch);
   assign preload_apply = preload_pending && instr_done;

   always_comb begin
      next_state = state;
      if (in_run && op == pcs_pkg::op_pattern_fetch) begin
         next_state = pcs_pkg::st_pat_second;
      end else if (!in_run) begin
         next_state = pcs_pkg::st_run;
      end
   end

   // Address part of the fetch counter
   always_comb begin
      next_addr = fetch_addr;
      if (in_run) begin
         case (op)
            pcs_pkg::op_in_page_jump: begin
               next_addr = jump_take ? rom_data[5:0] : succ_addr;
            end
            pcs_pkg::op_table_jump: begin
               next_addr = mix_addr;
            end
            default: begin
               // Pattern fetch counts on like any other instruction
               next_addr = succ_addr;
            end
         endcase
      end
   end

   // Page part: only a table jump or a due preload changes it
   always_comb begin
      next_page = fetch_page;
      if (in_run && op == pcs_pkg::op_table_jump) begin
         next_page = mix_page[`PCS_PAGE_W-1:0];
      end
      if (preload_apply) begin
         next_page = preload_page;
      end
   end

   // Memory address: the counter, or the substituted pattern address
   always_comb begin
      next_rom_page = {1'b0, next_page};
      next_rom_word = next_addr;
      if (in_run && op == pcs_pkg::op_pattern_fetch) begin
         next_rom_page = mix_page;
         next_rom_word = mix_addr;
      end
   end

   always_comb begin
      next_status = status_flag;
      if (status_load) begin
         next_status = status_value;
      end else if (in_run && op == pcs_pkg::op_in_page_jump
            && !status_flag) begin
         next_status = 1'b1;
      end
      // Preload skip and table jump leave the flag alone
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= pcs_pkg::st_run;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fetch_page <= `PCS_RST_PAGE;
         fetch_addr <= `PCS_RST_ADDR;
      end else begin
         fetch_page <= next_page;
         fetch_addr <= next_addr;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rom_page <= {1'b0, `PCS_RST_PAGE};
         rom_word <= `PCS_RST_ADDR;
      end else begin
         rom_page <= next_rom_page;
         rom_word <= next_rom_word;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status_flag <= 1'b1;
      end else begin
         status_flag <= next_status;
      end
   end

   // Preload waits for the end of the instruction that follows it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         preload_pending <= 1'b0;
         preload_page <= `PCS_RST_PAGE;
      end else if (preload_take) begin
         preload_pending <= 1'b1;
         preload_page <= rom_data[`PCS_PAGE_W-1:0];
      end else if (preload_apply) begin
         preload_pending <= 1'b0;
      end
   end

   // Interrupt controller must not take a request in this cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         int_hold <= 1'b0;
      end else begin
         int_hold <= (next_state == pcs_pkg::st_pat_second);
      end
   end

   // Destination routing of the fetched constant
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc_load <= 1'b0;
         acc_value <= 4'h0;
         aux_value <= 4'h0;
      end else begin
         acc_load <= !in_run && rom_data[`PCS_DEST_ACC_BIT];
         if (!in_run && rom_data[`PCS_DEST_ACC_BIT]) begin
            acc_value <= pcs_mirror(rom_data[3:0]);
            aux_value <= rom_data[7:4];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         io_load <= 1'b0;
         io_latch_two <= 4'h0;
         io_latch_three <= 4'h0;
      end else begin
         io_load <= !in_run && rom_data[`PCS_DEST_IO_BIT];
         if (!in_run && rom_data[`PCS_DEST_IO_BIT]) begin
            io_latch_two <= pcs_mirror(rom_data[7:4]);
            io_latch_three <= pcs_mirror(rom_data[3:0]);
         end
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   logic pat_now;
   logic run_plain;
   assign pat_now = in_run && (op == pcs_pkg::op_pattern_fetch);
   assign run_plain = in_run && (op == pcs_pkg::op_none);

   chk_poly_order: assert property (
      run_plain && !preload_pending |=> fetch_addr ==
      {$past(fetch_addr[4:0]), ~($past(fetch_addr[5]) ^ $past(fetch_addr[4]))
      ^ (&$past(fetch_addr[4:0]))} && fetch_page == $past(fetch_page))
      else $error("address part left the polynomial order");

   chk_page_hold: assert property (
      in_run && op == pcs_pkg::op_in_page_jump && !preload_pending
      |=> $stable(fetch_page))
      else $error("page part changed without a load");

   chk_prog_page: assert property (
      in_run && !pat_now |=> rom_page <= {1'b0, `PCS_PAGE_MAX})
      else $error("instruction fetch outside program pages");

   chk_pat_address: assert property (
      pat_now |=> rom_word == {$past(aux_in[1:0]), $past(acc_in)}
      && rom_page[4:0] == ($past(fetch_page) | {$past(rom_data[1:0]),
      $past(carry_in), $past(aux_in[3:2])}))
      else $error("pattern address not formed from operands");

   chk_pat_area: assert property (
      pat_now |=> rom_page[5] == $past(rom_data[`PCS_PAT_AREA_BIT]))
      else $error("pattern area bit not taken from operand");

   chk_pat_resume: assert property (
      pat_now && !preload_pending |=> ##1
      rom_word == $past(fetch_addr) && fetch_addr == $past(fetch_addr)
      && rom_page == {1'b0, fetch_page})
      else $error("fetch did not resume after pattern fetch");

   chk_pat_cycles: assert property (
      pat_now |=> state == pcs_pkg::st_pat_second ##1
      state == pcs_pkg::st_run)
      else $error("pattern fetch not two cycles");

   chk_int_window: assert property (
      pat_now |=> int_hold ##1 !int_hold)
      else $error("interrupt hold window wrong");

   chk_dest_route: assert property (
      !in_run |=> acc_load == $past(rom_data[8])
      && io_load == $past(rom_data[9])
      && (!io_load || io_latch_three == pcs_mirror($past(rom_data[3:0]))))
      else $error("constant routed to wrong destination");

   chk_jump_taken: assert property (
      jump_take && !preload_pending |=> fetch_addr == $past(rom_data[5:0])
      && fetch_page == $past(fetch_page))
      else $error("in-page jump target wrong");

   chk_jump_skip: assert property (
      in_run && op == pcs_pkg::op_in_page_jump && !status_flag
      && !status_load |=> status_flag
      && fetch_addr == $past(succ_addr))
      else $error("skipped in-page jump misbehaved");

   chk_preload_late: assert property (
      preload_take ##1 (run_plain && !status_load) |-> $stable(fetch_page)
      ##1 fetch_page == $past(preload_page))
      else $error("page preload not one instruction late");

   chk_preload_skip: assert property (
      in_run && op == pcs_pkg::op_page_preload && !status_flag
      && !status_load |=> !status_flag && !preload_pending)
      else $error("skipped preload changed flag or armed");

   chk_far_jump: assert property (
      preload_take ##1 jump_take |=> fetch_page == $past(preload_page)
      && fetch_addr == $past(rom_data[5:0]))
      else $error("far jump did not reach target page");

   chk_table_jump: assert property (
      in_run && op == pcs_pkg::op_table_jump && !status_load
      && !preload_pending |=> fetch_addr == {$past(aux_in[1:0]),
      $past(acc_in)} && status_flag == $past(status_flag))
      else $error("table jump wrong or flag disturbed");

   cov_pat_both: cover property (
      pat_now ##1 (rom_data[9] && rom_data[8]));
   cov_far_jump: cover property (preload_take ##1 jump_take);
   cov_table: cover property (
      in_run && op == pcs_pkg::op_table_jump && !status_flag);
   cov_skip_far: cover property (
      in_run && op == pcs_pkg::op_page_preload && !status_flag ##1
      in_run && op == pcs_pkg::op_in_page_jump);

endmodule : pcs_sequencer

// ==== verification/pcs_rom_model.sv ====
`timescale 1ns/1ps
`include "pcs_defs.svh"

module pcs_rom_model (
   // Address from the sequencer
   input wire logic [`PCS_PAGE_W:0] rom_page,
   input wire logic [`PCS_ADDR_W-1:0] rom_word,
   // Word read back
   output logic [`PCS_WORD_W-1:0] rom_data
);
   // 64 pages of 64 words; bit 5 of the page reaches the pattern area
   logic [`PCS_WORD_W-1:0] mem [0:4095];

   // Unwritten words hold a scrambled value, zero only where the low ten address bits are 2AA
   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = i[9:0] ^ 10'h2AA;
      end
   end

   assign rom_data = mem[{rom_page, rom_word}];
endmodule : pcs_rom_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "pcs_defs.svh"

module tb_top;
   logic sys_clk, rstn, carry_in, status_load, status_value;
   logic [9:0] rom_data;
   logic [5:0] rom_page, rom_word, fetch_addr;
   logic [4:0] fetch_page;
   logic [3:0] acc_in, aux_in, acc_value, aux_value;
   logic [3:0] io_latch_two, io_latch_three;
   logic status_flag, preload_pending, int_hold, acc_load, io_load;
   pcs_pkg::pcs_op_e op;
   int failures, cmp_count;

   pcs_sequencer pcs_sequencer_i (.sys_clk, .rstn, .rom_data, .rom_page,
      .rom_word, .op, .acc_in, .aux_in, .carry_in, .status_load,
      .status_value, .fetch_page, .fetch_addr, .status_flag,
      .preload_pending, .int_hold, .acc_load, .acc_value, .aux_value,
      .io_load, .io_latch_two, .io_latch_three);

   pcs_rom_model pcs_rom_model_i (.rom_page, .rom_word, .rom_data);

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize

   task chk(input string n, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Successor of the address part, worked out independently
   function automatic logic [5:0] succ(input logic [5:0] a);
      return {a[4:0], ~(a[5] ^ a[4]) ^ (&a[4:0])};
   endfunction : succ

   task put(input logic [5:0] pg, input logic [5:0] wd, input logic [9:0] k);
      pcs_rom_model_i.mem[{pg, wd}] = k;
   endtask : put

   // Inputs set on one edge are taken at the next; the fall shows the last
   task cyc(input pcs_pkg::pcs_op_e o, input logic [3:0] a = 4'h0,
         input logic [3:0] b = 4'h0, input logic c = 1'b0,
         input logic sl = 1'b0, input logic sv = 1'b0);
      @(posedge sys_clk);
      op <= o;
      acc_in <= a;
      aux_in <= b;
      carry_in <= c;
      status_load <= sl;
      status_value <= sv;
      @(negedge sys_clk);
   endtask : cyc

   task do_reset;
      @(posedge sys_clk);
      rstn <= 1'b0;
      op <= pcs_pkg::op_none;
      status_load <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      chk("fetch_page", 10'h000, fetch_page);
      chk("fetch_addr", 10'h03F, fetch_addr);
      chk("status_flag", 10'h001, status_flag);
      chk("int_hold", 10'h000, int_hold);
   endtask : do_reset

   task t_seq;
      logic [5:0] tab [0:7];
      logic [5:0] e;
      tab = '{6'h3F, 6'h3E, 6'h3D, 6'h3B, 6'h37, 6'h2F, 6'h1E, 6'h3C};
      e = 6'h3F;
      do_reset;
      for (int i = 1; i <= 64; i++) begin
         cyc(pcs_pkg::op_none);
         e = succ(e);
         if (i < 8) chk("table order", tab[i], fetch_addr);
         chk("fetch_addr", e, fetch_addr);
         chk("rom_word", e, rom_word);
         chk("fetch_page", 10'h000, fetch_page);
      end
      chk("wrap", 10'h03F, e);
      chk("zero step", 10'h001, succ(6'h00));
   endtask : t_seq

   task t_jump;
      do_reset;
      put(6'h00, 6'h3E, 10'h125);
      put(6'h00, succ(6'h25), 10'h111);
      cyc(pcs_pkg::op_in_page_jump);
      cyc(pcs_pkg::op_none, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
      chk("jump addr", 10'h025, fetch_addr);
      chk("jump page", 10'h000, fetch_page);
      cyc(pcs_pkg::op_in_page_jump);
      chk("flag cleared", 10'h000, status_flag);
      cyc(pcs_pkg::op_none);
      chk("skip addr", succ(succ(6'h25)), fetch_addr);
      chk("skip flag", 10'h001, status_flag);
   endtask : t_jump

   task t_preload;
      do_reset;
      put(6'h00, 6'h3E, 10'h005);
      put(6'h00, 6'h3D, 10'h120);
      put(6'h05, succ(6'h20), 10'h007);
      cyc(pcs_pkg::op_page_preload);
      cyc(pcs_pkg::op_in_page_jump);
      chk("pending", 10'h001, preload_pending);
      chk("old page", 10'h000, fetch_page);
      chk("next addr", 10'h03D, fetch_addr);
      cyc(pcs_pkg::op_none, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
      chk("far page", 10'h005, fetch_page);
      chk("far addr", 10'h020, fetch_addr);
      chk("pending", 10'h000, preload_pending);
      cyc(pcs_pkg::op_page_preload);
      cyc(pcs_pkg::op_none);
      chk("skip flag", 10'h000, status_flag);
      chk("pending", 10'h000, preload_pending);
      cyc(pcs_pkg::op_none);
      chk("kept page", 10'h005, fetch_page);
      put(6'h05, 6'h0F, 10'h00C);
      cyc(pcs_pkg::op_none, 4'h0, 4'h0, 1'b0, 1'b1, 1'b1);
      cyc(pcs_pkg::op_page_preload);
      cyc(pcs_pkg::op_none);
      chk("taken flag", 10'h001, status_flag);
      chk("pending", 10'h001, preload_pending);
      chk("late page", 10'h005, fetch_page);
      cyc(pcs_pkg::op_none);
      chk("new page", 10'h00C, fetch_page);
      chk("pending", 10'h000, preload_pending);
   endtask : t_preload

   task t_table;
      do_reset;
      put(6'h00, 6'h3D, 10'h001);
      cyc(pcs_pkg::op_none, 4'h0, 4'h0, 1'b0, 1'b1, 1'b0);
      cyc(pcs_pkg::op_table_jump, 4'h0, 4'hA, 1'b0);
      cyc(pcs_pkg::op_none);
      chk("table page", 10'h00A, fetch_page);
      chk("table addr", 10'h020, fetch_addr);
      chk("table flag", 10'h000, status_flag);
      chk("rom_word", 10'h020, rom_word);
   endtask : t_table

   task t_pat(input logic [2:0] p, input logic c, input logic [3:0] b,
         input logic [3:0] a, input logic [5:0] pg, input logic [5:0] wd,
         input logic [9:0] k);
      do_reset;
      put(6'h00, 6'h3E, {7'h00, p});
      put(pg, wd, k);
      cyc(pcs_pkg::op_pattern_fetch, a, b, c);
      // Second cycle: a jump class here must be ignored
      cyc(pcs_pkg::op_in_page_jump);
      chk("rom_page", pg, rom_page);
      chk("rom_word", wd, rom_word);
      chk("int_hold", 10'h001, int_hold);
      chk("fetch_addr", 10'h03D, fetch_addr);
      chk("fetch_page", 10'h000, fetch_page);
      cyc(pcs_pkg::op_none);
      chk("int_hold", 10'h000, int_hold);
      chk("acc_load", k[8], acc_load);
      chk("io_load", k[9], io_load);
      if (k[8]) chk("acc_value", 10'h00B, acc_value);
      if (k[8]) chk("aux_value", 10'h002, aux_value);
      if (k[9]) chk("io_latch_two", 10'h004, io_latch_two);
      if (k[9]) chk("io_latch_three", 10'h00B, io_latch_three);
      chk("rom_word", 10'h03D, rom_word);
      chk("fetch_addr", 10'h03D, fetch_addr);
      cyc(pcs_pkg::op_none);
      chk("acc_load", 10'h000, acc_load);
      chk("io_load", 10'h000, io_load);
      chk("fetch_addr", 10'h03B, fetch_addr);
   endtask : t_pat

   initial begin
      failures = 0;
      cmp_count = 0;
      rstn = 1'b0;
      op = pcs_pkg::op_none;
      acc_in = 4'h0;
      aux_in = 4'h0;
      carry_in = 1'b0;
      status_load = 1'b0;
      status_value = 1'b0;
      t_seq;
      t_jump;
      t_preload;
      t_table;
      t_pat(3'h1, 1'b0, 4'hA, 4'h0, 6'h0A, 6'h20, 10'h12D);
      t_pat(3'h7, 1'b1, 4'h4, 4'h0, 6'h3D, 6'h00, 10'h22D);
      t_pat(3'h1, 1'b0, 4'hA, 4'h0, 6'h0A, 6'h20, 10'h32D);
      summarize;
   end

   // Whole run needs some 160 cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      summarize;
   end
endmodule : tb_top
